/* rtl/excitation_mode_control.sv */
`timescale 1ns/1ps
module excitation_mode_control #(
    parameter int DEBOUNCE_CYC = excitation_mode_pkg::DEBOUNCE_CYCLES,
    parameter int RAMP_CYC = excitation_mode_pkg::RAMP_CYCLES,
    parameter int SAVE_CYC = excitation_mode_pkg::SAVE_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic [31:0] o_hrdata,
    input wire logic i_raise_input,
    input wire logic i_lower_input,
    input wire logic i_var_pf_limiter_select_input,
    input wire logic i_parallel_compensation_input,
    input wire logic i_voltage_match_input,
    input wire logic i_alarm,
    input wire logic i_sample_valid,
    input wire logic [11:0] i_field_voltage_sample,
    input wire logic [11:0] i_field_current_sample,
    output logic o_alarm_relay_output,
    output logic [5:0] o_mode,
    output logic [15:0] o_active_setpoint,
    output logic o_varpf_indicator,
    output logic o_oel_setpoint_select,
    output logic o_oel2_available,
    output logic o_excitation_limiter_available,
    output logic [11:0] o_field_voltage_dc,
    output logic [11:0] o_field_current_dc,
    output logic o_field_gate,
    output logic o_save_strobe
);
    logic [6:0] ctrl;
    logic [15:0] setpoint [4];
    logic [15:0] saved [4];
    logic [7:0] demand;
    logic [4:0] sync1, sync2, closed;
    logic [4:0] raw;
    localparam int CNT_W_L = excitation_mode_pkg::CNT_W;
    logic [CNT_W_L-1:0] deb_cnt [5];
    logic [CNT_W_L-1:0] ramp_cnt, save_cnt;
    logic save_pending;
    excitation_mode_pkg::mode_t mode, next_mode;
    logic [1:0] sp_idx;
    logic varpf_assigned, lim_assigned, varpf_on, vm_on;
    logic adj_up, adj_dn, ramp_tick;
    logic [15:0] sp_min, sp_max;
    logic [15:0] fv_acc, fi_acc;
    logic [3:0] acc_n;
    logic [7:0] pwm_cnt, duty;
    logic dp_active, dp_write;
    logic [7:0] dp_addr;
    logic [31:0] next_rdata;

    function automatic logic [15:0] lim_lo(input logic [1:0] idx);
        case (idx)
            excitation_mode_pkg::SP_FCR: lim_lo = excitation_mode_pkg::FCR_MIN;
            excitation_mode_pkg::SP_VAR: lim_lo = excitation_mode_pkg::VAR_MIN;
            excitation_mode_pkg::SP_PF: lim_lo = excitation_mode_pkg::PF_MIN;
            default: lim_lo = excitation_mode_pkg::AVR_MIN;
        endcase
    endfunction

    function automatic logic [15:0] lim_hi(input logic [1:0] idx);
        case (idx)
            excitation_mode_pkg::SP_FCR: lim_hi = excitation_mode_pkg::FCR_MAX;
            excitation_mode_pkg::SP_VAR: lim_hi = excitation_mode_pkg::VAR_MAX;
            excitation_mode_pkg::SP_PF: lim_hi = excitation_mode_pkg::PF_MAX;
            default: lim_hi = excitation_mode_pkg::AVR_MAX;
        endcase
    endfunction

    function automatic logic [15:0] clamp(input logic [15:0] v, input logic [1:0] idx);
        if (v < lim_lo(idx)) begin
            clamp = lim_lo(idx);
        end else if (v > lim_hi(idx)) begin
            clamp = lim_hi(idx);
        end else begin
            clamp = v;
        end
    endfunction

    // Contact synchroniser and debounce
    assign raw = {i_voltage_match_input, i_parallel_compensation_input,
        i_var_pf_limiter_select_input, i_lower_input, i_raise_input};

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sync1 <= 5'h00;
            sync2 <= 5'h00;
        end else begin
            sync1 <= raw;
            sync2 <= sync1;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            closed <= 5'h00;
            for (int k = 0; k < excitation_mode_pkg::N_IN; k++) begin
                deb_cnt[k] <= '0;
            end
        end else begin
            for (int k = 0; k < excitation_mode_pkg::N_IN; k++) begin
                if (sync2[k] == closed[k]) begin
                    deb_cnt[k] <= '0;
                end else if (deb_cnt[k] == CNT_W_L'(DEBOUNCE_CYC - 1)) begin
                    closed[k] <= sync2[k];
                    deb_cnt[k] <= '0;
                end else begin
                    deb_cnt[k] <= deb_cnt[k] + 1'b1;
                end
            end
        end
    end

    // Mode arbitration
    assign varpf_assigned = ctrl[excitation_mode_pkg::C_ASSIGN +: 2]
        == excitation_mode_pkg::ASSIGN_VARPF;
    assign lim_assigned = ctrl[excitation_mode_pkg::C_ASSIGN +: 2]
        == excitation_mode_pkg::ASSIGN_LIMITER;
    assign varpf_on = varpf_assigned && !closed[excitation_mode_pkg::I_SEL]
        && (ctrl[excitation_mode_pkg::C_VAR] || ctrl[excitation_mode_pkg::C_PF]);
    assign vm_on = ctrl[excitation_mode_pkg::C_VM] && closed[excitation_mode_pkg::I_VM]
        && closed[excitation_mode_pkg::I_SEL] && closed[excitation_mode_pkg::I_PAR];

    always_comb begin
        if (ctrl[excitation_mode_pkg::C_FCR]) begin
            next_mode = excitation_mode_pkg::M_FCR;
        end else if (varpf_on) begin
            next_mode = ctrl[excitation_mode_pkg::C_VAR] ? excitation_mode_pkg::M_VAR
                : excitation_mode_pkg::M_PF;
        end else if (vm_on) begin
            next_mode = excitation_mode_pkg::M_VMATCH;
        end else if (!closed[excitation_mode_pkg::I_PAR]) begin
            next_mode = excitation_mode_pkg::M_DROOP;
        end else begin
            next_mode = excitation_mode_pkg::M_AVR;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            mode <= excitation_mode_pkg::M_AVR;
        end else begin
            mode <= next_mode;
        end
    end

    always_comb begin
        case (mode)
            excitation_mode_pkg::M_FCR: sp_idx = excitation_mode_pkg::SP_FCR;
            excitation_mode_pkg::M_VAR: sp_idx = excitation_mode_pkg::SP_VAR;
            excitation_mode_pkg::M_PF: sp_idx = excitation_mode_pkg::SP_PF;
            default: sp_idx = excitation_mode_pkg::SP_AVR;
        endcase
    end

    // Setpoint ramp, save timer
    assign adj_up = closed[excitation_mode_pkg::I_RAISE] && !closed[excitation_mode_pkg::I_LOWER];
    assign adj_dn = closed[excitation_mode_pkg::I_LOWER] && !closed[excitation_mode_pkg::I_RAISE];
    assign ramp_tick = (adj_up || adj_dn) && ramp_cnt == CNT_W_L'(RAMP_CYC - 1);
    assign sp_min = lim_lo(sp_idx);
    assign sp_max = lim_hi(sp_idx);

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ramp_cnt <= '0;
        end else if (!(adj_up || adj_dn) || ramp_tick) begin
            ramp_cnt <= '0;
        end else begin
            ramp_cnt <= ramp_cnt + 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            setpoint[0] <= excitation_mode_pkg::AVR_RESET;
            setpoint[1] <= excitation_mode_pkg::FCR_RESET;
            setpoint[2] <= excitation_mode_pkg::VAR_RESET;
            setpoint[3] <= excitation_mode_pkg::PF_RESET;
        end else if (dp_write && dp_addr >= excitation_mode_pkg::A_SP
            && dp_addr < excitation_mode_pkg::A_SAVED) begin
            setpoint[dp_addr[3:2] - 2'h2] <= clamp(i_hwdata[15:0], dp_addr[3:2] - 2'h2);
        end else if (ramp_tick && adj_up && setpoint[sp_idx] < sp_max) begin
            setpoint[sp_idx] <= setpoint[sp_idx] + 16'h0001;
        end else if (ramp_tick && adj_dn && setpoint[sp_idx] > sp_min) begin
            setpoint[sp_idx] <= setpoint[sp_idx] - 16'h0001;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            save_pending <= 1'b0;
            save_cnt <= '0;
            o_save_strobe <= 1'b0;
            saved[0] <= excitation_mode_pkg::AVR_RESET;
            saved[1] <= excitation_mode_pkg::FCR_RESET;
            saved[2] <= excitation_mode_pkg::VAR_RESET;
            saved[3] <= excitation_mode_pkg::PF_RESET;
        end else begin
            o_save_strobe <= 1'b0;
            if (closed[excitation_mode_pkg::I_RAISE] || closed[excitation_mode_pkg::I_LOWER]) begin
                save_pending <= 1'b1;
                save_cnt <= '0;
            end else if (save_pending && save_cnt == CNT_W_L'(SAVE_CYC - 1)) begin
                save_pending <= 1'b0;
                save_cnt <= '0;
                o_save_strobe <= 1'b1;
                for (int k = 0; k < 4; k++) begin
                    saved[k] <= setpoint[k];
                end
            end else if (save_pending) begin
                save_cnt <= save_cnt + 1'b1;
            end
        end
    end

    // Field measurement averaging
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            fv_acc <= 16'h0000;
            fi_acc <= 16'h0000;
            acc_n <= 4'h0;
            o_field_voltage_dc <= 12'h000;
            o_field_current_dc <= 12'h000;
        end else if (i_sample_valid) begin
            acc_n <= acc_n + 4'h1;
            if (acc_n == 4'hF) begin
                o_field_voltage_dc <= 12'((fv_acc + 16'(i_field_voltage_sample))
                    >> excitation_mode_pkg::DC_SHIFT);
                o_field_current_dc <= 12'((fi_acc + 16'(i_field_current_sample))
                    >> excitation_mode_pkg::DC_SHIFT);
                fv_acc <= 16'h0000;
                fi_acc <= 16'h0000;
            end else begin
                fv_acc <= fv_acc + 16'(i_field_voltage_sample);
                fi_acc <= fi_acc + 16'(i_field_current_sample);
            end
        end
    end

    // Gating pulses; field current loop trims duty once per period
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pwm_cnt <= 8'h00;
            duty <= 8'h00;
            o_field_gate <= 1'b0;
        end else begin
            pwm_cnt <= pwm_cnt + 8'h01;
            if (pwm_cnt == 8'hFF) begin
                if (mode != excitation_mode_pkg::M_FCR) begin
                    duty <= demand;
                end else if (16'(o_field_current_dc) < setpoint[excitation_mode_pkg::SP_FCR]
                    && duty != 8'hFF) begin
                    duty <= duty + 8'h01;
                end else if (16'(o_field_current_dc) > setpoint[excitation_mode_pkg::SP_FCR]
                    && duty != 8'h00) begin
                    duty <= duty - 8'h01;
                end
            end
            o_field_gate <= !ctrl[excitation_mode_pkg::C_TRIP] && pwm_cnt < duty;
        end
    end

    // Outputs
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_alarm_relay_output <= 1'b0;
            o_varpf_indicator <= 1'b0;
            o_oel_setpoint_select <= 1'b0;
            o_oel2_available <= 1'b0;
            o_excitation_limiter_available <= 1'b0;
            o_active_setpoint <= 16'h0000;
        end else begin
            o_alarm_relay_output <= !i_alarm && !ctrl[excitation_mode_pkg::C_TRIP];
            o_varpf_indicator <= mode == excitation_mode_pkg::M_VAR
                || mode == excitation_mode_pkg::M_PF;
            o_oel_setpoint_select <= lim_assigned && !closed[excitation_mode_pkg::I_SEL];
            o_oel2_available <= !(varpf_on && ctrl[excitation_mode_pkg::C_VAR]);
            o_excitation_limiter_available <= !varpf_assigned
                && !(varpf_on && ctrl[excitation_mode_pkg::C_PF]);
            o_active_setpoint <= setpoint[sp_idx];
        end
    end
    assign o_mode = mode;

    // AHB-Lite slave, zero wait states
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;

    always_comb begin
        next_rdata = 32'h0000_0000;
        if (i_haddr[7:0] == excitation_mode_pkg::A_CTRL) begin
            next_rdata = 32'(ctrl);
        end else if (i_haddr[7:0] == excitation_mode_pkg::A_STATUS) begin
            next_rdata = {19'h0, save_pending, o_alarm_relay_output, closed, mode};
        end else if (i_haddr[7:0] >= excitation_mode_pkg::A_SP
            && i_haddr[7:0] < excitation_mode_pkg::A_SAVED) begin
            next_rdata = 32'(setpoint[i_haddr[3:2] - 2'h2]);
        end else if (i_haddr[7:0] >= excitation_mode_pkg::A_SAVED
            && i_haddr[7:0] < excitation_mode_pkg::A_FIELD_V) begin
            next_rdata = 32'(saved[i_haddr[3:2] - 2'h2]);
        end else if (i_haddr[7:0] == excitation_mode_pkg::A_FIELD_V) begin
            next_rdata = 32'(o_field_voltage_dc);
        end else if (i_haddr[7:0] == excitation_mode_pkg::A_FIELD_I) begin
            next_rdata = 32'(o_field_current_dc);
        end else if (i_haddr[7:0] == excitation_mode_pkg::A_DEMAND) begin
            next_rdata = 32'(demand);
        end
        if (i_haddr[31:8] != 24'h000000) begin
            next_rdata = 32'h0000_0000;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            dp_active <= 1'b0;
            dp_write <= 1'b0;
            dp_addr <= 8'h00;
            o_hrdata <= 32'h0000_0000;
        end else if (i_hready) begin
            dp_active <= i_hsel && i_htrans == excitation_mode_pkg::HTRANS_NONSEQ;
            dp_write <= i_hsel && i_htrans == excitation_mode_pkg::HTRANS_NONSEQ && i_hwrite
                && i_haddr[31:8] == 24'h000000 && i_haddr[7:0] <= excitation_mode_pkg::A_LAST;
            dp_addr <= i_haddr[7:0];
            o_hrdata <= next_rdata;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctrl <= excitation_mode_pkg::CTRL_RESET;
            demand <= 8'h00;
        end else if (dp_write && dp_addr == excitation_mode_pkg::A_CTRL) begin
            ctrl <= i_hwdata[6:0];
        end else if (dp_write && dp_addr == excitation_mode_pkg::A_DEMAND) begin
            demand <= i_hwdata[7:0];
        end
    end

    // Checks
    property p_vm_forced_off;
        @(posedge i_clk) disable iff (!i_reset_n)
        !closed[excitation_mode_pkg::I_SEL] || !closed[excitation_mode_pkg::I_PAR]
            |=> mode != excitation_mode_pkg::M_VMATCH;
    endproperty
    a_vm_forced_off: assert property (p_vm_forced_off) else $error("vm not forced off");

    property p_varpf_priority;
        @(posedge i_clk) disable iff (!i_reset_n)
        varpf_on && !ctrl[excitation_mode_pkg::C_FCR] |=> o_mode[2] || o_mode[3];
    endproperty
    a_varpf_priority: assert property (p_varpf_priority) else $error("var/pf not chosen");

    property p_droop;
        @(posedge i_clk) disable iff (!i_reset_n)
        !closed[excitation_mode_pkg::I_PAR] && !varpf_on && !ctrl[excitation_mode_pkg::C_FCR]
            |=> mode == excitation_mode_pkg::M_DROOP;
    endproperty
    a_droop: assert property (p_droop) else $error("droop mode missing");

    property p_indicator;
        @(posedge i_clk) disable iff (!i_reset_n)
        ##1 o_varpf_indicator == ($past(mode) == excitation_mode_pkg::M_VAR
            || $past(mode) == excitation_mode_pkg::M_PF);
    endproperty
    a_indicator: assert property (p_indicator) else $error("indicator mismatch");

    property p_alarm;
        @(posedge i_clk) disable iff (!i_reset_n)
        i_alarm |=> !o_alarm_relay_output;
    endproperty
    a_alarm: assert property (p_alarm) else $error("relay closed under alarm");

    property p_raise_no_fall;
        @(posedge i_clk) disable iff (!i_reset_n)
        adj_up && !dp_write && $stable(sp_idx) |=> setpoint[$past(sp_idx)]
            >= $past(setpoint[sp_idx]);
    endproperty
    a_raise_no_fall: assert property (p_raise_no_fall) else $error("setpoint fell on raise");

    property p_fcr_range;
        @(posedge i_clk) disable iff (!i_reset_n)
        setpoint[excitation_mode_pkg::SP_FCR] >= excitation_mode_pkg::FCR_MIN
            && setpoint[excitation_mode_pkg::SP_FCR] <= excitation_mode_pkg::FCR_MAX;
    endproperty
    a_fcr_range: assert property (p_fcr_range) else $error("field setpoint out of range");

    property p_save_restart;
        @(posedge i_clk) disable iff (!i_reset_n)
        closed[excitation_mode_pkg::I_RAISE] |=> save_pending && save_cnt == '0 && !o_save_strobe;
    endproperty
    a_save_restart: assert property (p_save_restart) else $error("save not restarted");

    property p_save_copy;
        @(posedge i_clk) disable iff (!i_reset_n)
        o_save_strobe |-> saved[excitation_mode_pkg::SP_AVR] == $past(setpoint[0]);
    endproperty
    a_save_copy: assert property (p_save_copy) else $error("saved value wrong");

    property p_oel2;
        @(posedge i_clk) disable iff (!i_reset_n)
        varpf_on && ctrl[excitation_mode_pkg::C_VAR] |=> !o_oel2_available;
    endproperty
    a_oel2: assert property (p_oel2) else $error("second limiter available");

    c_varpf: cover property (@(posedge i_clk) disable iff (!i_reset_n)
        mode == excitation_mode_pkg::M_VAR);
    c_vmatch: cover property (@(posedge i_clk) disable iff (!i_reset_n)
        mode == excitation_mode_pkg::M_VMATCH);
    c_save: cover property (@(posedge i_clk) disable iff (!i_reset_n) o_save_strobe);
endmodule

/* rtl/excitation_mode_pkg.sv */
package excitation_mode_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int SAVE_DELAY_MS = 2000;
    localparam int SAVE_CYCLES = SAVE_DELAY_MS * (CLK_HZ / 1000);
    localparam int DEBOUNCE_MS = 20;
    localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * (CLK_HZ / 1000);
    localparam int RAMP_MS = 50;
    localparam int RAMP_CYCLES = RAMP_MS * (CLK_HZ / 1000);
    localparam int CNT_W = 26;
    localparam int N_IN = 5;
    localparam int DC_SHIFT = 4;
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STATUS = 8'h04;
    localparam logic [7:0] A_SP = 8'h08;
    localparam logic [7:0] A_SAVED = 8'h18;
    localparam logic [7:0] A_FIELD_V = 8'h28;
    localparam logic [7:0] A_FIELD_I = 8'h2C;
    localparam logic [7:0] A_DEMAND = 8'h30;
    localparam logic [7:0] A_LAST = 8'h30;
    localparam int C_ASSIGN = 0;
    localparam int C_VAR = 2;
    localparam int C_PF = 3;
    localparam int C_VM = 4;
    localparam int C_FCR = 5;
    localparam int C_TRIP = 6;
    localparam logic [6:0] CTRL_RESET = 7'h00;
    localparam logic [1:0] ASSIGN_VARPF = 2'h1;
    localparam logic [1:0] ASSIGN_LIMITER = 2'h2;
    localparam int I_RAISE = 0;
    localparam int I_LOWER = 1;
    localparam int I_SEL = 2;
    localparam int I_PAR = 3;
    localparam int I_VM = 4;
    localparam logic [1:0] SP_AVR = 2'h0;
    localparam logic [1:0] SP_FCR = 2'h1;
    localparam logic [1:0] SP_VAR = 2'h2;
    localparam logic [1:0] SP_PF = 2'h3;
    // Field current in 0.01 A steps, var in percent offset by 100, pf 0.6 lag..0.6 lead
    localparam logic [15:0] AVR_MIN = 16'h0000;
    localparam logic [15:0] AVR_MAX = 16'hFFFF;
    localparam logic [15:0] FCR_MIN = 16'h0003;
    localparam logic [15:0] FCR_MAX = 16'h02BC;
    localparam logic [15:0] VAR_MIN = 16'h0000;
    localparam logic [15:0] VAR_MAX = 16'h00C8;
    localparam logic [15:0] PF_MIN = 16'h0000;
    localparam logic [15:0] PF_MAX = 16'h0050;
    localparam logic [15:0] AVR_RESET = 16'h1000;
    localparam logic [15:0] FCR_RESET = 16'h0064;
    localparam logic [15:0] VAR_RESET = 16'h0064;
    localparam logic [15:0] PF_RESET = 16'h0028;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    typedef enum logic [5:0] {
        M_AVR = 6'h01,
        M_FCR = 6'h02,
        M_VAR = 6'h04,
        M_PF = 6'h08,
        M_DROOP = 6'h10,
        M_VMATCH = 6'h20
    } mode_t;
endpackage

/* testbench/contact_panel.sv */
`timescale 1ns/1ps
module contact_panel (
    input wire logic i_clk,
    input wire logic [4:0] i_cmd,
    input wire logic i_chatter,
    output logic [4:0] o_contacts
);
    // Dry contacts; chatter makes every contact bounce each cycle
    always_ff @(posedge i_clk) begin
        o_contacts <= i_chatter ? ~o_contacts : i_cmd;
    end
endmodule

/* testbench/testbench.sv */
`timescale 1ns/1ps
module testbench;
    logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, alarm = 0, sv = 0, chat = 0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, q;
    logic [4:0] cmd = 5'h00;
    logic [11:0] samp = 12'h000;
    logic [15:0] v;
    wire hready, relay, ind, sstr, overexcitation_limiter, oel2, elim, gate;
    wire [31:0] rdata;
    wire [5:0] mode;
    wire [15:0] sp;
    wire [11:0] dcv, dci;
    wire [4:0] ct;
    int err_total = 0, total_checks = 0, n;
    typedef struct packed {logic [7:0] c; logic [4:0] k; logic [5:0] m; logic i;} row_t;
    row_t rows [9] = '{'{8'h00, 5'h00, 6'h10, 1'b0}, '{8'h00, 5'h08, 6'h01, 1'b0},
        '{8'h05, 5'h00, 6'h04, 1'b1}, '{8'h05, 5'h04, 6'h10, 1'b0},
        '{8'h09, 5'h00, 6'h08, 1'b1}, '{8'h10, 5'h1C, 6'h20, 1'b0},
        '{8'h10, 5'h18, 6'h01, 1'b0}, '{8'h20, 5'h00, 6'h02, 1'b0},
        '{8'h04, 5'h00, 6'h10, 1'b0}};
    contact_panel panel (.i_clk(clk), .i_cmd(cmd), .i_chatter(chat), .o_contacts(ct));
    excitation_mode_control #(.DEBOUNCE_CYC(4), .RAMP_CYC(8), .SAVE_CYC(32)) dut (
        .i_clk(clk), .i_reset_n(rst_n), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
        .o_hreadyout(hready), .o_hresp(), .o_hrdata(rdata), .i_raise_input(ct[0]),
        .i_lower_input(ct[1]), .i_var_pf_limiter_select_input(ct[2]),
        .i_parallel_compensation_input(ct[3]), .i_voltage_match_input(ct[4]),
        .i_alarm(alarm), .i_sample_valid(sv), .i_field_voltage_sample(samp),
        .i_field_current_sample(samp), .o_alarm_relay_output(relay), .o_mode(mode),
        .o_active_setpoint(sp), .o_varpf_indicator(ind), .o_oel_setpoint_select(overexcitation_limiter),
        .o_oel2_available(oel2), .o_excitation_limiter_available(elim),
        .o_field_voltage_dc(dcv), .o_field_current_dc(dci), .o_field_gate(gate),
        .o_save_strobe(sstr));
    initial begin
        forever #50 clk = ~clk;
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        q = rdata;
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", s, e, g);
            err_total++;
        end
    endtask
    task results;
        if (err_total == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        results;
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        foreach (rows[r]) begin
            xfer(1'b1, 8'h00, {24'h000000, rows[r].c});
            cmd <= rows[r].k;
            repeat (12) @(posedge clk);
            chk("mode", rows[r].m, mode);
            chk("indicator", rows[r].i, ind);
        end
        xfer(1'b1, 8'h30, 32'h80);
        cmd <= 5'h08;
        xfer(1'b1, 8'h00, 32'h02);
        repeat (12) @(posedge clk);
        chk("oel select open", 1, overexcitation_limiter);
        chk("limiter avail", 1, elim);
        cmd <= 5'h0C;
        repeat (12) @(posedge clk);
        chk("oel select closed", 0, overexcitation_limiter);
        cmd <= 5'h08;
        xfer(1'b1, 8'h00, 32'h05);
        repeat (12) @(posedge clk);
        chk("oel2 var", 0, oel2);
        chk("limiter var", 0, elim);
        xfer(1'b1, 8'h00, 32'h09);
        repeat (12) @(posedge clk);
        chk("oel2 pf", 1, oel2);
        chk("limiter pf", 0, elim);
        xfer(1'b1, 8'h00, 32'h00);
        repeat (512) @(posedge clk);
        n = 0;
        repeat (256) begin
            @(posedge clk);
            n += gate;
        end
        chk("gate duty", 32'h80, n);
        xfer(1'b1, 8'h00, 32'h40);
        repeat (2) @(posedge clk);
        chk("relay trip", 0, relay);
        n = 0;
        repeat (256) begin
            @(posedge clk);
            n += gate;
        end
        chk("gate trip", 0, n);
        xfer(1'b1, 8'h00, 32'h00);
        alarm <= 1'b1;
        repeat (3) @(posedge clk);
        chk("relay alarm", 0, relay);
        alarm <= 1'b0;
        repeat (3) @(posedge clk);
        chk("relay healthy", 1, relay);
        xfer(1'b0, 8'h40, 32'h0);
        chk("unmapped", 0, q);
        chat <= 1'b1;
        repeat (20) @(posedge clk);
        chk("chatter mode", 6'h01, mode);
        chat <= 1'b0;
        xfer(1'b1, 8'h00, 32'h20);
        repeat (3) @(posedge clk);
        v = sp;
        cmd <= 5'h09;
        repeat (60) @(posedge clk);
        chk("raise", 1, sp > v);
        cmd <= 5'h08;
        repeat (20) @(posedge clk);
        cmd <= 5'h09;
        repeat (10) @(posedge clk);
        cmd <= 5'h08;
        n = 0;
        while (sstr !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        chk("save delay", 1, n >= 32 && n <= 60);
        xfer(1'b0, 8'h1C, 32'h0);
        chk("saved", {16'h0000, sp}, q);
        v = sp;
        cmd <= 5'h0A;
        repeat (60) @(posedge clk);
        chk("lower", 1, sp < v);
        samp <= 12'h123;
        sv <= 1'b1;
        repeat (16) @(posedge clk);
        sv <= 1'b0;
        repeat (3) @(posedge clk);
        chk("field v", 12'h123, dcv);
        chk("field i", 12'h123, dci);
        results;
    end
endmodule
